// [agc_loop_gain_filter_pkg.sv]
// Constants for the automatic gain control loop core

`default_nettype none

package agc_loop_gain_filter_pkg;

  // Register port
  localparam int unsigned ADDR_WIDTH          = 8;
  localparam int unsigned DATA_WIDTH          = 32;
  localparam logic [7:0]  LOOP_PARAM_OFFSET   = 8'h00;
  localparam logic [7:0]  LOOP_OUTPUT_OFFSET  = 8'h04;
  localparam logic [31:0] LOOP_PARAM_RESET    = 32'h0000_FF00;

  // Loop parameter register fields
  localparam int unsigned DISABLE_BIT         = 31;
  localparam int unsigned SCALE_LSB           = 27;
  localparam int unsigned SCALE_WIDTH         = 4;
  localparam int unsigned SHIFT_LSB           = 24;
  localparam int unsigned SHIFT_WIDTH         = 3;
  localparam int unsigned THRESHOLD_LSB       = 16;
  localparam int unsigned UPPER_LSB           = 8;
  localparam int unsigned LOWER_LSB           = 0;
  localparam int unsigned BYTE_WIDTH          = 8;

  // Data path widths
  localparam int unsigned MAG_WIDTH           = 8;
  localparam int unsigned ERROR_WIDTH         = 9;
  localparam int unsigned PRODUCT_WIDTH       = 13;
  localparam int unsigned FRACTION_WIDTH      = 11;
  localparam int unsigned ACC_WIDTH           = 19;
  localparam int unsigned SUM_WIDTH           = 21;
  localparam int unsigned OUT_MANT_WIDTH      = 6;
  localparam int unsigned OUT_EXP_WIDTH       = 2;
  localparam int unsigned GAIN_WIDTH          = 10;
  localparam int unsigned GAIN_FRACTION       = 6;
  localparam int unsigned SAMPLE_WIDTH        = 10;
  localparam int unsigned SAMPLE_PRODUCT      = 21;

  // Shift that moves the error product onto the accumulator LSB
  localparam int unsigned ALIGN_SHIFT         = 1;

  localparam logic [ACC_WIDTH-1:0] ACC_RESET  = 19'h0_0000;

endpackage

`default_nettype wire

// [agc_loop_gain_filter.sv]
// Automatic gain control loop: error detector, loop gain, clamped integrator, gain decode, I/Q multipliers
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.

`default_nettype none

module agc_loop_gain_filter
(
  input  wire logic                                                  i_clock,
  input  wire logic                                                  i_reset_n,
  input  wire logic [agc_loop_gain_filter_pkg::ADDR_WIDTH-1:0]       i_address,
  input  wire logic [agc_loop_gain_filter_pkg::DATA_WIDTH-1:0]       i_write_data,
  input  wire logic                                                  i_write,
  input  wire logic                                                  i_read,
  output var  logic [agc_loop_gain_filter_pkg::DATA_WIDTH-1:0]       o_read_data,
  input  wire logic [agc_loop_gain_filter_pkg::MAG_WIDTH-1:0]        i_magnitude,
  input  wire logic                                                  i_magnitude_valid,
  input  wire logic signed [agc_loop_gain_filter_pkg::SAMPLE_WIDTH-1:0] i_sample_i,
  input  wire logic signed [agc_loop_gain_filter_pkg::SAMPLE_WIDTH-1:0] i_sample_q,
  input  wire logic                                                  i_sample_valid,
  output var  logic signed [agc_loop_gain_filter_pkg::SAMPLE_WIDTH-1:0] o_sample_i,
  output var  logic signed [agc_loop_gain_filter_pkg::SAMPLE_WIDTH-1:0] o_sample_q,
  output var  logic                                                  o_sample_valid,
  output var  logic [agc_loop_gain_filter_pkg::BYTE_WIDTH-1:0]       o_gain_code,
  output var  logic [agc_loop_gain_filter_pkg::GAIN_WIDTH-1:0]       o_multiplier_gain_factor
);

  localparam int unsigned AW = agc_loop_gain_filter_pkg::ACC_WIDTH;
  localparam int unsigned SW = agc_loop_gain_filter_pkg::SUM_WIDTH;
  localparam int unsigned EW = agc_loop_gain_filter_pkg::ERROR_WIDTH;
  localparam int unsigned PW = agc_loop_gain_filter_pkg::PRODUCT_WIDTH;
  localparam int unsigned FW = agc_loop_gain_filter_pkg::FRACTION_WIDTH;
  localparam int unsigned BW = agc_loop_gain_filter_pkg::BYTE_WIDTH;
  localparam int unsigned GW = agc_loop_gain_filter_pkg::GAIN_WIDTH;
  localparam int unsigned XW = agc_loop_gain_filter_pkg::SAMPLE_WIDTH;
  localparam int unsigned MW = agc_loop_gain_filter_pkg::SAMPLE_PRODUCT;

  // Decodes an e/m byte into the linear gain (1 + m) * 2^e, six fraction bits
  function automatic logic [GW-1:0] decode_gain
  (
    input logic [BW-1:0] code
  );
    logic [GW-1:0] unity_plus_mantissa;
    unity_plus_mantissa = {3'h0, 1'b1, code[agc_loop_gain_filter_pkg::OUT_MANT_WIDTH-1:0]};
    decode_gain = unity_plus_mantissa << code[BW-1 -: agc_loop_gain_filter_pkg::OUT_EXP_WIDTH];
  endfunction

  // Scales one sample by the gain and saturates to the sample width
  function automatic logic signed [XW-1:0] apply_gain
  (
    input logic signed [XW-1:0] sample,
    input logic        [GW-1:0] gain
  );
    logic signed [MW-1:0] product;
    logic signed [MW-1:0] scaled;
    logic signed [MW-1:0] max_value;
    logic signed [MW-1:0] min_value;
    product   = MW'(sample) * $signed({1'b0, gain});
    scaled    = product >>> agc_loop_gain_filter_pkg::GAIN_FRACTION;
    max_value = MW'(signed'({1'b0, {(XW-1){1'b1}}}));
    min_value = MW'(signed'({1'b1, {(XW-1){1'b0}}}));
    if (scaled > max_value)
    begin
      apply_gain = max_value[XW-1:0];
    end
    else if (scaled < min_value)
    begin
      apply_gain = min_value[XW-1:0];
    end
    else
    begin
      apply_gain = scaled[XW-1:0];
    end
  endfunction

  logic [31:0]   loop_param;
  logic [AW-1:0] accumulator;

  // Register decode
  wire logic hit_param   = (i_address == agc_loop_gain_filter_pkg::LOOP_PARAM_OFFSET);
  wire logic hit_output  = (i_address == agc_loop_gain_filter_pkg::LOOP_OUTPUT_OFFSET);
  wire logic write_param = i_write && hit_param;

  // Loop parameter fields
  wire logic loop_disable = loop_param[agc_loop_gain_filter_pkg::DISABLE_BIT];

  wire logic [agc_loop_gain_filter_pkg::SCALE_WIDTH-1:0] gain_scale_code =
    loop_param[agc_loop_gain_filter_pkg::SCALE_LSB +: agc_loop_gain_filter_pkg::SCALE_WIDTH];

  wire logic [agc_loop_gain_filter_pkg::SHIFT_WIDTH-1:0] gain_shift_code =
    loop_param[agc_loop_gain_filter_pkg::SHIFT_LSB +: agc_loop_gain_filter_pkg::SHIFT_WIDTH];

  wire logic [BW-1:0] loop_threshold =
    loop_param[agc_loop_gain_filter_pkg::THRESHOLD_LSB +: BW];

  wire logic [BW-1:0] upper_limit = loop_param[agc_loop_gain_filter_pkg::UPPER_LSB +: BW];
  wire logic [BW-1:0] lower_limit = loop_param[agc_loop_gain_filter_pkg::LOWER_LSB +: BW];

  // Error detector: both operands share the 2^0 .. 2^-7 weighting
  wire logic signed [EW-1:0] raw_error =
    $signed({1'b0, i_magnitude}) - $signed({1'b0, loop_threshold});

  wire logic signed [EW-1:0] loop_error =
    loop_disable ? EW'(0) : raw_error;

  // Mantissa product; its LSB weighs 2^-11 since the code is read as code/16
  wire logic signed [PW-1:0] scaled_error =
    PW'(loop_error) * $signed({1'b0, gain_scale_code});

  // Product times 2^-(7+E), expressed in accumulator LSBs of 2^-17
  wire logic signed [SW-1:0] loop_input =
    SW'(scaled_error) >>> (agc_loop_gain_filter_pkg::ALIGN_SHIFT + gain_shift_code);

  // Integrator; low bits of the shift are dropped, so tiny positive errors never move it, while tiny negative ones round down to -1
  wire logic signed [SW-1:0] raw_sum =
    $signed({2'b00, accumulator}) + loop_input;

  // Limits cover their whole byte, including every fraction bit below it
  wire logic signed [SW-1:0] upper_bound =
    $signed({2'b00, upper_limit, {FW{1'b1}}});

  wire logic signed [SW-1:0] lower_bound =
    $signed({2'b00, lower_limit, {FW{1'b0}}});

  // Upper limit is checked first, so with crossed limits any sum above the upper one goes to it and every other sum goes to the lower one
  wire logic [AW-1:0] next_accumulator =
    (raw_sum > upper_bound) ? upper_bound[AW-1:0] :
    (raw_sum < lower_bound) ? lower_bound[AW-1:0] :
    raw_sum[AW-1:0];

  wire logic [BW-1:0] next_gain_code = accumulator[AW-1 -: BW];

  wire logic [GW-1:0] next_multiplier_gain_factor = decode_gain(next_gain_code);

  wire logic signed [XW-1:0] next_sample_i = apply_gain(i_sample_i, o_multiplier_gain_factor);
  wire logic signed [XW-1:0] next_sample_q = apply_gain(i_sample_q, o_multiplier_gain_factor);

  wire logic [31:0] next_read_data =
    !i_read    ? 32'h0000_0000 :
    hit_param  ? loop_param :
    hit_output ? {24'h00_0000, o_gain_code} :
    32'h0000_0000;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      loop_param <= agc_loop_gain_filter_pkg::LOOP_PARAM_RESET;
    end
    else if (write_param)
    begin
      loop_param <= i_write_data;
    end
  end

  // Only magnitudes flagged valid update the loop, so idle cycles hold the gain
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      accumulator <= agc_loop_gain_filter_pkg::ACC_RESET;
    end
    else if (i_magnitude_valid)
    begin
      accumulator <= next_accumulator;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      o_gain_code              <= 8'h00;
      o_multiplier_gain_factor <= 10'h040;
    end
    else
    begin
      o_gain_code              <= next_gain_code;
      o_multiplier_gain_factor <= next_multiplier_gain_factor;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      o_sample_i     <= 10'h000;
      o_sample_q     <= 10'h000;
      o_sample_valid <= 1'b0;
    end
    else
    begin
      o_sample_i     <= next_sample_i;
      o_sample_q     <= next_sample_q;
      o_sample_valid <= i_sample_valid;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      o_read_data <= 32'h0000_0000;
    end
    else
    begin
      o_read_data <= next_read_data;
    end
  end

endmodule

`default_nettype wire

// [agc_loop_gain_filter_properties.sv]
// Port-level checks on the AGC loop core
`default_nettype none
module agc_loop_checker
(
  input wire logic              i_clock,
  input wire logic              i_reset_n,
  input wire logic [7:0]        i_address,
  input wire logic [31:0]       i_write_data,
  input wire logic              i_write,
  input wire logic              i_read,
  input wire logic [31:0]       o_read_data,
  input wire logic              i_magnitude_valid,
  input wire logic signed [9:0] i_sample_i,
  input wire logic signed [9:0] i_sample_q,
  input wire logic              i_sample_valid,
  input wire logic signed [9:0] o_sample_i,
  input wire logic signed [9:0] o_sample_q,
  input wire logic              o_sample_valid,
  input wire logic [7:0]        o_gain_code,
  input wire logic [9:0]        o_multiplier_gain_factor
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0]        shadow;
  logic signed [20:0] prod_i;
  logic signed [20:0] prod_q;
  logic signed [9:0]  exp_i;
  logic signed [9:0]  exp_q;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  function automatic logic signed [9:0] sat(input logic signed [20:0] p);
    return (p > 21'sh001FF) ? 10'h1FF : (p < -21'sh00200) ? 10'h200 : p[9:0];
  endfunction
  assign prod_i = (i_sample_i * $signed({1'b0, o_multiplier_gain_factor})) >>> 6;
  assign prod_q = (i_sample_q * $signed({1'b0, o_multiplier_gain_factor})) >>> 6;
  // Shadow of the loop parameter word, so limits can be judged from ports alone
  // Expected samples follow the design's reset, so the first edge after release compares zero with zero
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      shadow <= 32'h0000FF00;
      exp_i  <= 10'h000;
      exp_q  <= 10'h000;
    end
    else
    begin
      if (i_write && i_address == 8'h00)
        shadow <= i_write_data;
      exp_i <= sat(prod_i);
      exp_q <= sat(prod_q);
    end
  end
  sequence s_loop_update;
    i_magnitude_valid ##2 1'b1;
  endsequence
  a_read_idle_zero: assert property (!(i_read && (i_address == 8'h00 || i_address == 8'h04)) |=>
    o_read_data == 32'h0) else $error("read data not zero");
  a_param_readback: assert property (i_read && i_address == 8'h00 |=> o_read_data == $past(shadow))
    else $error("loop parameter readback wrong");
  a_output_readback: assert property (i_read && i_address == 8'h04 |=>
    o_read_data == {24'h0, $past(o_gain_code)}) else $error("gain code readback wrong");
  a_gain_in_limits: assert property (s_loop_update |-> $past(shadow[7:0], 2) > $past(shadow[15:8], 2) ||
    (o_gain_code <= $past(shadow[15:8], 2) && o_gain_code >= $past(shadow[7:0], 2)))
    else $error("gain code outside limits");
  a_hold_disabled: assert property ($past(shadow[31], 2) && $past(shadow[15:0], 2) == 16'hFF00 |->
    $stable(o_gain_code)) else $error("gain moved while loop disabled");
  a_factor_decode: assert property (o_multiplier_gain_factor == 10'({4'h1, o_gain_code[5:0]} << o_gain_code[7:6]))
    else $error("gain factor decode wrong");
  a_sample_scale: assert property (o_sample_i == exp_i && o_sample_q == exp_q)
    else $error("scaled sample wrong");
  a_valid_latency: assert property (1'b1 |=> o_sample_valid == $past(i_sample_valid))
    else $error("sample valid latency wrong");
endmodule
bind agc_loop_gain_filter agc_loop_checker checker_inst
(
  .i_clock                  (i_clock),
  .i_reset_n                (i_reset_n),
  .i_address                (i_address),
  .i_write_data             (i_write_data),
  .i_write                  (i_write),
  .i_read                   (i_read),
  .o_read_data              (o_read_data),
  .i_magnitude_valid        (i_magnitude_valid),
  .i_sample_i               (i_sample_i),
  .i_sample_q               (i_sample_q),
  .i_sample_valid           (i_sample_valid),
  .o_sample_i               (o_sample_i),
  .o_sample_q               (o_sample_q),
  .o_sample_valid           (o_sample_valid),
  .o_gain_code              (o_gain_code),
  .o_multiplier_gain_factor (o_multiplier_gain_factor)
);
`default_nettype wire

// [agc_front_model.sv]
// Magnitude and sample source standing upstream of the AGC loop core
`default_nettype none
module agc_front_model
(
  input  wire logic              i_clock,
  input  wire logic              i_reset_n,
  input  wire logic              i_run,
  input  wire logic              i_slow,
  input  wire logic [7:0]        i_level,
  output var  logic [7:0]        o_magnitude,
  output var  logic              o_magnitude_valid,
  output var  logic signed [9:0] o_sample,
  output var  logic              o_sample_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle cycles show the inverted last value so a stale magnitude is never mistaken for data
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      o_magnitude_valid <= 1'b0;
      o_magnitude       <= 8'h00;
      o_sample          <= 10'h000;
      o_sample_valid    <= 1'b0;
    end
    else
    begin
      o_magnitude_valid <= i_run && !(i_slow && o_magnitude_valid);
      o_magnitude       <= (i_run && !(i_slow && o_magnitude_valid)) ? i_level : ~o_magnitude;
      o_sample          <= o_sample + 10'h05B;
      o_sample_valid    <= !o_sample_valid;
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the AGC loop core
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              i_clock;
  logic              i_reset_n;
  logic [7:0]        i_address;
  logic [31:0]       i_write_data;
  logic              i_write;
  logic              i_read;
  logic [31:0]       o_read_data;
  logic              run;
  logic              slow;
  logic [7:0]        level;
  logic [7:0]        magnitude;
  logic              magnitude_valid;
  logic signed [9:0] sample;
  logic              sample_valid;
  logic [7:0]        o_gain_code;
  logic [9:0]        o_multiplier_gain_factor;
  int                n_fail;
  int                n_checks;
  int                n_upd;
  int                acc;
`define CHECK(g, x) begin n_checks++; if ((g) !== (x)) begin n_fail++; \
  $display("unexpected at %0t got %h expected %h", $time, g, x); end end
  agc_front_model front (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_run(run), .i_slow(slow), .i_level(level),
    .o_magnitude(magnitude), .o_magnitude_valid(magnitude_valid), .o_sample(sample), .o_sample_valid(sample_valid));
  agc_loop_gain_filter uut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_address(i_address),
    .i_write_data(i_write_data), .i_write(i_write), .i_read(i_read), .o_read_data(o_read_data),
    .i_magnitude(magnitude), .i_magnitude_valid(magnitude_valid), .i_sample_i(sample), .i_sample_q(~sample),
    .i_sample_valid(sample_valid), .o_sample_i(), .o_sample_q(), .o_sample_valid(), .o_gain_code(o_gain_code),
    .o_multiplier_gain_factor(o_multiplier_gain_factor));
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock)
    if (magnitude_valid)
      n_upd <= n_upd + 1;
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset();
    i_reset_n <= 1'b0;
    acc = 0;
    repeat (5) @(posedge i_clock);
    i_reset_n <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_address    <= a;
    i_write_data <= d;
    i_write      <= 1'b1;
    @(posedge i_clock);
    i_write      <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    i_address <= a;
    i_read    <= 1'b1;
    @(posedge i_clock);
    i_read    <= 1'b0;
    @(posedge i_clock);
    `CHECK(o_read_data, x)
  endtask
  // Expected top byte is rebuilt from the number of updates the source really issued
  task automatic loop_case(input logic [31:0] p, input logic [7:0] lv, input logic s);
    int e;
    int inc;
    int hi;
    int lo;
    wr(8'h00, p);
    level <= lv;
    slow  <= s;
    run   <= 1'b1;
    n_upd = 0;
    repeat (300) @(posedge i_clock);
    run <= 1'b0;
    repeat (4) @(posedge i_clock);
    e   = p[31] ? 0 : int'(lv) - int'(p[23:16]);
    inc = (e * int'(p[30:27])) >>> (1 + p[26:24]);
    hi  = int'({p[15:8], 11'h7FF});
    lo  = int'({p[7:0], 11'h000});
    repeat (n_upd) acc = (acc + inc > hi) ? hi : (acc + inc < lo) ? lo : acc + inc;
    `CHECK(o_gain_code, acc[18:11])
    `CHECK(o_multiplier_gain_factor, 10'({4'h1, acc[16:11]} << acc[18:17]))
    rd(8'h04, {24'h0, acc[18:11]});
    rd(8'h00, p);
  endtask
  // Register port straight after reset: reset word, read-only output word, unmapped address
  task automatic reg_port_case();
    rd(8'h00, 32'h0000FF00);
    `CHECK(o_multiplier_gain_factor, 10'h040)
    `CHECK(o_gain_code, 8'h00)
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h00, 32'h0000FF00);
  endtask
  initial
  begin
    #500000;
    n_fail++;
    end_sim();
  end
  initial
  begin
    {i_reset_n, i_address, i_write_data, i_write, i_read, run, slow, level} = '0;
    n_upd = 0;
    do_reset();
    reg_port_case();
    for (int i = 0; i < 16; i++)
    begin
      do_reset();
      loop_case({i == 15, 4'(i), 3'(i), 8'h80, 8'hC0 - 8'(i * 3), 8'h20 + 8'(i)}, i[0] ? 8'h30 : 8'hFF, i[1]);
    end
    do_reset();
    loop_case(32'h7B00FF00, 8'hFF, 1'b0);
    loop_case(32'h7A802810, 8'hFF, 1'b0);
    loop_case(32'hFB00FF00, 8'h00, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
